// File: rxfm_consts.vh
`ifndef RXFM_CONSTS_VH
`define RXFM_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RXFM_OFF_CTRL     12'h000
`define RXFM_OFF_STATUS   12'h004
`define RXFM_OFF_IRQ_STAT 12'h008
`define RXFM_OFF_IRQ_MASK 12'h00C
`define RXFM_OFF_MEASURE  12'h010
`define RXFM_ADDR_W       12

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define RXFM_CTRL_SINGLE_RAIL 0
`define RXFM_CTRL_FALL_EDGE   1
`define RXFM_CTRL_RATE_STS1   2
`define RXFM_CTRL_SFM         3
`define RXFM_CTRL_W           4
`define RXFM_CTRL_RESET       4'h0

// ------------------------------------------------------------
// status and interrupt fields
// ------------------------------------------------------------
`define RXFM_ST_LOCK_LOST  0
`define RXFM_ST_MEAS_VALID 1
`define RXFM_IRQ_LOL_SET   0
`define RXFM_IRQ_LOL_CLR   1
`define RXFM_IRQ_VIOL      2
`define RXFM_IRQ_W         3
`define RXFM_IRQ_RESET     3'h0

// ------------------------------------------------------------
// loss-of-lock comparison
// ------------------------------------------------------------
`define RXFM_LOL_PPM      32'h00001388
`define RXFM_PPM_SCALE    32'h000F4240
`define RXFM_LOL_WINDOW   12'h3E8
`define RXFM_CNT_W        12
`define RXFM_CNT_MAX      12'hFFF

// ------------------------------------------------------------
// pin sampling
// ------------------------------------------------------------
`define RXFM_NUM_PINS     8
`define RXFM_PIN_RCLK     0
`define RXFM_PIN_E3REF    1
`define RXFM_PIN_STS1REF  2
`define RXFM_PIN_SYNTH    3
`define RXFM_PIN_POS      4
`define RXFM_PIN_NEG      5
`define RXFM_PIN_LCV      6
`define RXFM_PIN_EXZ      7

`define RXFM_HTRANS_NONSEQ_BIT 1

`endif

// File: rxfm_output_lock.v
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rxfm_consts.vh"
// Behaviour
// R1: the lock-lost flag output is high while loss of lock is declared and low otherwise.
// R2: loss of lock is declared when the recovered clock deviates from its reference by 0.5% (5000 ppm) or more.
// R3: the reference is the selected rate clock, or the synthesizer output in single-frequency mode.
// R4: in dual-rail mode a positive line pulse raises the positive output for exactly one recovered period.
// R5: in dual-rail mode a negative line pulse raises the negative output for exactly one recovered period.
// R6: in single-rail mode the positive output carries the full recovered stream, one bit per period.
// R7: data outputs change only on the configured recovered clock edge, rising or falling.
// R8: in single-rail mode the negative output becomes the violation indicator.
// R9: in single-rail mode a violation or excessive-zeros event holds the indicator high at least one period.
// R10: in dual-rail mode positive data goes to the positive pin and negative data to the negative pin.
// R11: in single-rail mode the violation indicator updates on the same edge as the data pin.
// R12: in dual-rail mode each output is low in every period with no pulse of its polarity.
// R13: the frequency comparison runs continuously and the flag clears when deviation falls below threshold.
module rxfm_output_lock (
  input wire hclk,                             // bus and sampling clock
  input wire hresetn,                          // async reset, active low
  input wire hsel,                             // slave select
  input wire [31:0] haddr,                     // byte address
  input wire [1:0] htrans,                     // transfer type
  input wire hwrite,                           // write when high
  input wire [2:0] hsize,                      // transfer size
  input wire [31:0] hwdata,                    // write data
  input wire hready,                           // bus ready in
  output wire hreadyout,                       // slave ready
  output wire hresp,                           // response, always okay
  output reg [31:0] hrdata,                    // read data
  output wire irq,                             // level interrupt
  input wire recovered_clock_pin,              // recovered clock
  input wire e3_rate_reference_clock,          // e3 rate reference
  input wire sts1_rate_reference_clock,        // sts-1 rate reference
  input wire synth_reference_clock,            // synthesizer output
  input wire line_positive_pulse,              // positive pulse seen on line_receive_inputs
  input wire line_negative_pulse,              // negative pulse seen on line_receive_inputs
  input wire line_code_violation,              // decoder violation
  input wire excessive_zeros_event,            // excessive zeros detected
  output reg rx_positive_mark_out,             // positive data / data
  output reg rx_negative_mark_out,             // negative data / violation flag
  output reg lock_lost_flag_out                // loss of lock flag
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam [`RXFM_CNT_W-1:0] WINDOW = `RXFM_LOL_WINDOW;
  // tolerance rounded up so a deviation of exactly 0.5% still trips
  localparam [31:0] TOL_INT = (`RXFM_LOL_WINDOW * `RXFM_LOL_PPM + `RXFM_PPM_SCALE - 32'h00000001) / `RXFM_PPM_SCALE;
  localparam [`RXFM_CNT_W-1:0] TOL = TOL_INT[`RXFM_CNT_W-1:0];
  localparam [`RXFM_CNT_W-1:0] HI_LIMIT = WINDOW + TOL;
  localparam [`RXFM_CNT_W-1:0] LO_LIMIT = WINDOW - TOL;

  // ------------------------------------------------------------
  // pin sampling: three flops, change taken when last two agree
  // ------------------------------------------------------------
  wire [`RXFM_NUM_PINS-1:0] pin_raw;
  wire [`RXFM_NUM_PINS-1:0] pin_filt;
  wire [`RXFM_NUM_PINS-1:0] pin_prev;

  assign pin_raw = {excessive_zeros_event, line_code_violation, line_negative_pulse,
                    line_positive_pulse, synth_reference_clock, sts1_rate_reference_clock,
                    e3_rate_reference_clock, recovered_clock_pin};

  genvar gi;
  generate
    for (gi = 0; gi < `RXFM_NUM_PINS; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg filt;
      reg prev;
      // one driver per bit keeps the vectors single-sourced
      assign pin_filt[gi] = filt;
      assign pin_prev[gi] = prev;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          filt <= 1'b0;
          prev <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt <= s3;
          end
          prev <= filt;
        end
      end
    end
  endgenerate

  wire [`RXFM_NUM_PINS-1:0] pin_rise = pin_filt & ~pin_prev;
  wire [`RXFM_NUM_PINS-1:0] pin_fall = ~pin_filt & pin_prev;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [`RXFM_CTRL_W-1:0] ctrl;
  reg [`RXFM_IRQ_W-1:0] irq_stat;
  reg [`RXFM_IRQ_W-1:0] irq_mask;
  reg [`RXFM_CNT_W-1:0] last_measure;
  reg meas_valid;

  wire single_rail = ctrl[`RXFM_CTRL_SINGLE_RAIL];
  wire fall_edge = ctrl[`RXFM_CTRL_FALL_EDGE];

  // ------------------------------------------------------------
  // output stage, launched on the chosen recovered edge
  // ------------------------------------------------------------
  wire launch = fall_edge ? pin_fall[`RXFM_PIN_RCLK] : pin_rise[`RXFM_PIN_RCLK]; // [R7]
  wire pos_in = pin_filt[`RXFM_PIN_POS];
  wire neg_in = pin_filt[`RXFM_PIN_NEG];
  wire viol_in = pin_filt[`RXFM_PIN_LCV] | pin_filt[`RXFM_PIN_EXZ];
  reg next_pos;
  reg next_neg;

  always @* begin
    if (single_rail) begin
      next_pos = pos_in | neg_in;           // [R6]
      next_neg = viol_in;                   // [R8] [R9]
    end else begin
      next_pos = pos_in;                    // [R4] [R10] [R12]
      next_neg = neg_in;                    // [R5] [R10] [R12]
    end
  end

  // both pins share one launch so the indicator never skews from data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_positive_mark_out <= 1'b0;
      rx_negative_mark_out <= 1'b0;
    end else if (launch) begin
      rx_positive_mark_out <= next_pos;     // [R7]
      rx_negative_mark_out <= next_neg;     // [R11]
    end
  end

  // violation event for the interrupt, once per launched period
  wire viol_event = launch & single_rail & viol_in;

  // ------------------------------------------------------------
  // lock monitor: recovered edges per reference window
  // ------------------------------------------------------------
  wire sel_ref_rise = ctrl[`RXFM_CTRL_SFM] ? pin_rise[`RXFM_PIN_SYNTH] :
                      ctrl[`RXFM_CTRL_RATE_STS1] ? pin_rise[`RXFM_PIN_STS1REF] :
                      pin_rise[`RXFM_PIN_E3REF];   // [R3]
  wire rec_rise = pin_rise[`RXFM_PIN_RCLK];
  reg [`RXFM_CNT_W-1:0] ref_cnt;
  reg [`RXFM_CNT_W-1:0] rec_cnt;
  wire window_end = sel_ref_rise && (ref_cnt == WINDOW - 12'h001);
  // a recovered edge on the closing cycle still belongs to this window
  wire [`RXFM_CNT_W-1:0] rec_final = (rec_rise && rec_cnt != `RXFM_CNT_MAX) ? rec_cnt + 12'h001 : rec_cnt;
  wire deviates = (rec_final >= HI_LIMIT) || (rec_final <= LO_LIMIT); // [R2]

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt <= 12'h000;
      rec_cnt <= 12'h000;
      lock_lost_flag_out <= 1'b0;
      last_measure <= 12'h000;
      meas_valid <= 1'b0;
    end else if (window_end) begin
      ref_cnt <= 12'h000;
      rec_cnt <= 12'h000;
      lock_lost_flag_out <= deviates;       // [R1] [R13]
      last_measure <= rec_final;
      meas_valid <= 1'b1;
    end else begin
      if (sel_ref_rise) begin
        ref_cnt <= ref_cnt + 12'h001;
      end
      rec_cnt <= rec_final;                 // [R13]
    end
  end

  reg lol_prev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lol_prev <= 1'b0;
    end else begin
      lol_prev <= lock_lost_flag_out;
    end
  end

  wire [`RXFM_IRQ_W-1:0] irq_events;
  assign irq_events[`RXFM_IRQ_LOL_SET] = lock_lost_flag_out & ~lol_prev;
  assign irq_events[`RXFM_IRQ_LOL_CLR] = ~lock_lost_flag_out & lol_prev;
  assign irq_events[`RXFM_IRQ_VIOL] = viol_event;

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  function [31:0] read_mux;
    input [`RXFM_ADDR_W-1:0] a;
    begin
      case (a)
        `RXFM_OFF_CTRL: read_mux = {28'h0000000, ctrl};
        `RXFM_OFF_STATUS: read_mux = {30'h00000000, meas_valid, lock_lost_flag_out};
        `RXFM_OFF_IRQ_STAT: read_mux = {29'h00000000, irq_stat};
        `RXFM_OFF_IRQ_MASK: read_mux = {29'h00000000, irq_mask};
        `RXFM_OFF_MEASURE: read_mux = {20'h00000, last_measure};
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  wire addr_phase = hsel & htrans[`RXFM_HTRANS_NONSEQ_BIT] & hready;
  reg wr_pend;
  reg [`RXFM_ADDR_W-1:0] wr_addr;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= haddr[`RXFM_ADDR_W-1:0];
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= read_mux(haddr[`RXFM_ADDR_W-1:0]);
      end
    end
  end

  wire wr_ctrl = wr_pend && (wr_addr == `RXFM_OFF_CTRL);
  wire wr_istat = wr_pend && (wr_addr == `RXFM_OFF_IRQ_STAT);
  wire wr_mask = wr_pend && (wr_addr == `RXFM_OFF_IRQ_MASK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `RXFM_CTRL_RESET;
      irq_mask <= `RXFM_IRQ_RESET;
      irq_stat <= `RXFM_IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[`RXFM_CTRL_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[`RXFM_IRQ_W-1:0];
      end
      // a new event in the clearing cycle survives the clear
      irq_stat <= (irq_stat & ~(wr_istat ? hwdata[`RXFM_IRQ_W-1:0] : `RXFM_IRQ_RESET)) | irq_events;
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule

// File: rxfm_chk_assertions.sv
`timescale 1ns/10ps
module rxfm_chk (
  input wire hclk, // bus clock
  input wire hresetn, // async reset, low
  input wire hreadyout, // slave ready
  input wire hresp, // response
  input wire line_positive_pulse, // pos mark in
  input wire line_negative_pulse, // neg mark in
  input wire line_code_violation, // violation in
  input wire excessive_zeros_event, // zeros event in
  input wire rx_positive_mark_out, // pos / data out
  input wire rx_negative_mark_out, // neg / violation out
  input wire lock_lost_flag_out // lock flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a held input spans one launch edge, whichever edge is selected
  sequence s_pos_held;
    line_positive_pulse [*8];
  endsequence
  sequence s_neg_held;
    (line_negative_pulse && line_code_violation) [*8];
  endsequence
  sequence s_pos_quiet;
    (!line_positive_pulse && !line_negative_pulse) [*8] ##1 (!line_positive_pulse && !line_negative_pulse) [*4];
  endsequence
  sequence s_neg_quiet;
    (!line_negative_pulse && !line_code_violation && !excessive_zeros_event) [*8] ##1
      (!line_negative_pulse && !line_code_violation && !excessive_zeros_event) [*4];
  endsequence
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_pos_mark_high: assert property (s_pos_held |-> ##[0:6] rx_positive_mark_out)
    else $error("positive output missed a held mark");
  a_pos_idle_low: assert property (s_pos_quiet |=> ##1 !rx_positive_mark_out)
    else $error("positive output high with no mark");
  a_neg_mark_high: assert property (s_neg_held |-> ##[0:6] rx_negative_mark_out)
    else $error("negative output missed a held mark");
  a_neg_idle_low: assert property (s_neg_quiet |=> ##1 !rx_negative_mark_out)
    else $error("negative output high with no cause");
  a_pos_full_period: assert property ($rose(rx_positive_mark_out) |=> rx_positive_mark_out [*6])
    else $error("positive mark shorter than a period");
  a_neg_full_period: assert property ($rose(rx_negative_mark_out) |=> rx_negative_mark_out [*6])
    else $error("negative mark shorter than a period");
  a_flag_window_hold: assert property ($changed(lock_lost_flag_out) |=> $stable(lock_lost_flag_out) [*8])
    else $error("lock flag toggled inside a window");
  a_flag_reset_low: assert property ($rose(hresetn) |-> !lock_lost_flag_out [*8])
    else $error("lock flag high before any measurement");
endmodule
bind rxfm_output_lock rxfm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .line_positive_pulse(line_positive_pulse), .line_negative_pulse(line_negative_pulse),
  .line_code_violation(line_code_violation), .excessive_zeros_event(excessive_zeros_event),
  .rx_positive_mark_out(rx_positive_mark_out), .rx_negative_mark_out(rx_negative_mark_out),
  .lock_lost_flag_out(lock_lost_flag_out));

// File: rxfm_far_model.sv
`timescale 1ns/10ps
module rxfm_far_model (
  input wire fall_launch, // launch edge is falling
  input wire [3:0] next_bits, // pos, neg, lcv, exz
  input wire mark_pos, // positive output
  input wire mark_neg, // negative output
  output logic rclk, // recovered clock
  output logic [3:0] lines, // pos, neg, lcv, exz
  output logic [1:0] seen, // captured outputs
  output int launches // launch edge count
);
  initial begin
    rclk = 1'b0;
    lines = 4'h0;
    seen = 2'h0;
    launches = 0;
  end
  // free-running like a real recovered clock, phase unrelated to hclk
  initial begin
    #13;
    forever #400 rclk = ~rclk;
  end
  always @(rclk) begin
    if (rclk != fall_launch) begin
      // outputs settle 4-5 hclk late, so they are taken one period on
      seen <= {mark_pos, mark_neg};
      launches <= launches + 1;
    end else begin
      lines <= next_bits;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/10ps
`include "rxfm_consts.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic e3_clk = 1'b0;
  logic sts1_clk = 1'b0;
  logic synth_clk = 1'b0;
  logic fall = 1'b0;
  logic [3:0] next_bits = 4'h0;
  logic [31:0] rd;
  wire hready, hresp, irq, rclk, opos, oneg, loss_of_lock;
  wire [31:0] hrdata;
  wire [3:0] lines;
  wire [1:0] seen;
  int launches;
  int num_errors = 0;
  int checks_done = 0;
  always #50 hclk = ~hclk;
  initial begin #17; forever #400 e3_clk = ~e3_clk; end
  initial begin #29; forever #395 sts1_clk = ~sts1_clk; end
  initial begin #41; forever #400 synth_clk = ~synth_clk; end
  rxfm_output_lock u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .recovered_clock_pin(rclk), .e3_rate_reference_clock(e3_clk),
    .sts1_rate_reference_clock(sts1_clk), .synth_reference_clock(synth_clk), .line_positive_pulse(lines[3]),
    .line_negative_pulse(lines[2]), .line_code_violation(lines[1]), .excessive_zeros_event(lines[0]),
    .rx_positive_mark_out(opos), .rx_negative_mark_out(oneg), .lock_lost_flag_out(loss_of_lock));
  rxfm_far_model u_far (.fall_launch(fall), .next_bits(next_bits), .mark_pos(opos), .mark_neg(oneg),
    .rclk(rclk), .lines(lines), .seen(seen), .launches(launches));
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail_hang;
    num_errors++;
    stop_test;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      if (++k > 50) fail_hang;
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask
  // one bit per recovered period, set just after a launch edge
  task automatic put(input logic [3:0] v);
    int n, k;
    n = launches;
    k = 0;
    while (launches == n) begin
      @(posedge hclk);
      if (++k > 40) fail_hang;
    end
    next_bits <= v;
  endtask
  // entries of {pos, neg, lcv, exz, expected pos out, expected neg out}
  task automatic stream(input logic [47:0] tab);
    for (int i = 0; i < 8; i++) begin
      put(tab[47-6*i -: 4]);
      if (i > 1) chk("marks", {30'h0, tab[55-6*i -: 2]}, {30'h0, seen});
    end
  endtask
  task automatic scn_regs;
    bus(`RXFM_OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(`RXFM_OFF_STATUS, 1'b0, 32'h0);
    chk("status reset", 32'h0, rd);
    bus(12'h014, 1'b1, 32'hFFFFFFFF);
    bus(12'h014, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(`RXFM_OFF_IRQ_MASK, 1'b1, 32'h7);
    bus(`RXFM_OFF_IRQ_MASK, 1'b0, 32'h0);
    chk("mask", 32'h7, rd);
  endtask
  task automatic scn_stream;
    stream({6'h22, 6'h00, 6'h11, 6'h22, 6'h22, 6'h0C, 6'h00, 6'h00});
    bus(`RXFM_OFF_CTRL, 1'b1, 32'h3);
    fall <= 1'b1;
    stream({6'h22, 6'h12, 6'h09, 6'h05, 6'h00, 6'h1B, 6'h00, 6'h00});
    chk("viol irq", 32'h1, {31'h0, irq});
    bus(`RXFM_OFF_IRQ_STAT, 1'b1, 32'h4);
    bus(`RXFM_OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("viol clear", 32'h0, rd);
    chk("irq low", 32'h0, {31'h0, irq});
  endtask
  // three phases of 17000 hclk cycles, just over two windows each
  task automatic scn_lock;
    bus(`RXFM_OFF_CTRL, 1'b1, 32'h0);
    repeat (17000) @(posedge hclk);
    bus(`RXFM_OFF_STATUS, 1'b0, 32'h0);
    chk("locked e3", 32'h2, rd);
    bus(`RXFM_OFF_MEASURE, 1'b0, 32'h0);
    chk("measure near window", 32'h1, {31'h0, (rd >= 32'd996 && rd <= 32'd1004)});
    chk("flag low", 32'h0, {31'h0, loss_of_lock});
    bus(`RXFM_OFF_CTRL, 1'b1, 32'h4);
    repeat (17000) @(posedge hclk);
    bus(`RXFM_OFF_STATUS, 1'b0, 32'h0);
    chk("lost sts1", 32'h3, rd);
    chk("flag high", 32'h1, {31'h0, loss_of_lock});
    chk("irq rose", 32'h1, {31'h0, irq});
    bus(`RXFM_OFF_CTRL, 1'b1, 32'hC);
    repeat (17000) @(posedge hclk);
    bus(`RXFM_OFF_STATUS, 1'b0, 32'h0);
    chk("synth lock", 32'h2, rd);
    chk("flag clear", 32'h0, {31'h0, loss_of_lock});
    bus(`RXFM_OFF_IRQ_MASK, 1'b1, 32'h0);
    bus(`RXFM_OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("stat both", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(`RXFM_OFF_IRQ_STAT, 1'b1, 32'h7);
    bus(`RXFM_OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("stat clear", 32'h0, rd);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    scn_regs;
    scn_stream;
    scn_lock;
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    fail_hang;
  end
endmodule
